// file: verilog/ptwb_window_buffer.sv
// Functional notes
// [R1] ring buffer stores every sample consecutively, wrapping to zero at end
// [R2] each trigger copies window samples plus time and count to secondary
// [R3] host supplies block placement instead of deriving it from window length
// [R4] secondary memory holds 2040 words, four blocks of 500 samples
// [R5] trigger pushes time stamp and window start pointer into 16-bit queue
// [R6] 48-bit time stamp takes four queue entries, low slice first
// [R7] low slice tagged 1100, other three slices tagged 0100
// [R8] first queue entry raises has-entry flag and starts the copy engine
// [R9] queued pointer is the first primary address read for the copy
// [R10] copy stops when sample count equals window length
// [R11] count of ready blocks, decremented by downstream after each block
// [R12] blocks start at fixed addresses, multiples of the block pitch
// [R13] block opens with four time words tagged 1000, high slice lowest
// [R14] then trigger count bits 26-14 tagged 010, bits 13-0 tagged 01
// [R15] samples tagged 000, final window sample tagged 001
// [R16] sample four words before block end tagged 111
// [R17] simultaneous decrement and increment: decrement applied first
// [R18] ready count rises by one per completed block copy
// [R19] trigger faster than copy sets sticky copy overrun until reset
// [R20] ready count reaching host maximum sets sticky block overrun
// [R21] sample storing never pauses while copying or processing
// [R22] each trigger assertion detected once, giving one record and block
`timescale 1ns/1ns
`default_nettype none
module ptwb_window_buffer (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [ptwb_pkg::SMP_W-1:0] adc_data,
   input wire logic adc_valid,
   input wire logic trig_n,
   input wire logic blk_dec,
   input wire logic [ptwb_pkg::SEC_AW-1:0] sec_rd_addr,
   output logic [ptwb_pkg::WORD_W-1:0] sec_rd_data,
   output logic [2:0] blocks_ready
);
   import ptwb_pkg::*;

   // wrap-aware ring arithmetic on the primary pointer
   function automatic logic [11:0] ring_inc(input logic [11:0] p);
      ring_inc = (p == PRI_LAST) ? 12'h000 : p + 12'h001;
   endfunction

   function automatic logic [11:0] ring_sub(input logic [11:0] a,
                                            input logic [11:0] b);
      ring_sub = (a >= b) ? a - b : a + PRI_DEPTH_W - b;
   endfunction

   // ---------------- apb slave ----------------
   logic [10:0] win_ff;
   logic [11:0] lat_ff;
   logic [10:0] stride_ff;
   logic [2:0] maxblk_ff;
   logic srst_ff;
   logic copy_ovr_ff;
   logic blk_ovr_ff;
   logic [26:0] trig_num_ff;
   ptwb_state_t st_ff;
   logic has_entry;
   wire apb_setup = psel && !penable;
   wire apb_wr = psel && penable && pready && pwrite;
   wire hit_win = (paddr == OFS_WIN);
   wire hit_lat = (paddr == OFS_LAT);
   wire hit_str = (paddr == OFS_STRIDE);
   wire hit_max = (paddr == OFS_MAXBLK);
   wire hit_ctl = (paddr == OFS_CTRL);
   wire hit_sta = (paddr == OFS_STATUS);
   wire hit_num = (paddr == OFS_TRIGNUM);
   wire unmapped = !(hit_win || hit_lat || hit_str || hit_max || hit_ctl
                     || hit_sta || hit_num);
   wire [31:0] status_w = {24'h000000, (st_ff != PTWB_IDLE), has_entry,
                           copy_ovr_ff, blk_ovr_ff, 1'b0, blocks_ready};
   wire [31:0] rd_mux = hit_win ? {21'h0, win_ff} :
                        hit_lat ? {20'h0, lat_ff} :
                        hit_str ? {21'h0, stride_ff} :
                        hit_max ? {29'h0, maxblk_ff} :
                        hit_sta ? status_w :
                        hit_num ? {5'h00, trig_num_ff} : 32'h0;

   // read data is latched in setup so the answer comes off a flop
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= apb_setup;
         prdata <= apb_setup ? rd_mux : 32'h00000000;
         pslverr <= apb_setup && unmapped;
      end
   end

   // configuration registers; ctrl bit 0 fires the soft reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         win_ff <= WIN_RST;
         lat_ff <= LAT_RST;
         stride_ff <= STRIDE_RST;
         maxblk_ff <= MAXBLK_RST;
         srst_ff <= 1'b0;
      end else if (ce) begin
         if (apb_wr && hit_win) win_ff <= pwdata[10:0];
         if (apb_wr && hit_lat) lat_ff <= pwdata[11:0];
         if (apb_wr && hit_str) stride_ff <= pwdata[10:0]; // [R3]
         if (apb_wr && hit_max) maxblk_ff <= pwdata[2:0];
         srst_ff <= apb_wr && hit_ctl && pwdata[0];
      end
   end

   // ---------------- primary ring ----------------
   logic [SMP_W-1:0] pri_mem [PRI_DEPTH];
   logic [11:0] wr_ptr_ff;
   logic [11:0] rd_ptr_ff;
   logic [SMP_W-1:0] pri_q_ff;
   logic issue;

   // storing ignores soft reset and engine state so no sample is lost
   always_ff @(posedge clk_sys) begin
      if (ce && adc_valid) begin
         pri_mem[wr_ptr_ff] <= adc_data; // [R1] [R21]
      end
      if (ce) begin
         pri_q_ff <= pri_mem[rd_ptr_ff];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_ff <= 12'h000;
      end else if (ce && adc_valid) begin
         wr_ptr_ff <= ring_inc(wr_ptr_ff); // [R1]
      end
   end

   // ---------------- trigger pin and queue push ----------------
   logic trig_s1_ff;
   logic trig_s2_ff;
   logic trig_s3_ff;
   logic trig_lvl_ff;
   logic [47:0] time_stamp_ff;
   logic [47:0] ts_cap_ff;
   logic [11:0] window_start_pointer_ff;
   logic pushing_ff;
   logic [2:0] push_idx_ff;
   logic [TQ_AW:0] tq_free;
   logic [WORD_W-1:0] tq_head;
   logic tq_pop;
   wire clr = srst_ff;
   wire trig_agree = (trig_s2_ff == trig_s3_ff);
   wire trig_det = trig_agree && !trig_s2_ff && trig_lvl_ff;
   wire room = !pushing_ff && (tq_free >= TQ_REC);
   wire trig_take = trig_det && room;
   wire [WORD_W-1:0] push_data =
      (push_idx_ff == 3'h0) ? {TQ_TAG_START, ts_cap_ff[11:0]} :
      (push_idx_ff == 3'h1) ? {TQ_TAG_TS, ts_cap_ff[23:12]} :
      (push_idx_ff == 3'h2) ? {TQ_TAG_TS, ts_cap_ff[35:24]} :
      (push_idx_ff == 3'h3) ? {TQ_TAG_TS, ts_cap_ff[47:36]} :
      {TQ_TAG_PTR, window_start_pointer_ff}; // [R5] [R6] [R7]

   // three stages; edge detector fires when s2 and s3 agree low while the filtered level is still high
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         trig_s1_ff <= 1'b1;
         trig_s2_ff <= 1'b1;
         trig_s3_ff <= 1'b1;
         trig_lvl_ff <= 1'b1;
         time_stamp_ff <= 48'h000000000000;
      end else if (ce) begin
         trig_s1_ff <= trig_n;
         trig_s2_ff <= trig_s1_ff;
         trig_s3_ff <= trig_s2_ff;
         if (trig_agree) trig_lvl_ff <= trig_s2_ff; // [R22]
         time_stamp_ff <= clr ? 48'h000000000000 : time_stamp_ff + 48'h1;
      end
   end

   // five back-to-back pushes per accepted trigger
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pushing_ff <= 1'b0;
         push_idx_ff <= 3'h0;
         ts_cap_ff <= 48'h000000000000;
         window_start_pointer_ff <= 12'h000;
      end else if (ce) begin
         if (clr) begin
            pushing_ff <= 1'b0;
            push_idx_ff <= 3'h0;
         end else if (trig_take) begin
            pushing_ff <= 1'b1; // [R22]
            push_idx_ff <= 3'h0;
            ts_cap_ff <= time_stamp_ff;
            window_start_pointer_ff <= ring_sub(wr_ptr_ff, lat_ff); // [R5]
         end else if (pushing_ff) begin
            pushing_ff <= (push_idx_ff != TQ_LAST_IDX);
            push_idx_ff <= push_idx_ff + 3'h1;
         end
      end
   end

   ptwb_trig_queue u_tq (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .clr(clr),
      .push(pushing_ff),
      .push_data(push_data),
      .pop(tq_pop),
      .head(tq_head),
      .has_entry(has_entry),
      .free(tq_free)
   );

   // ---------------- copy engine ----------------
   ptwb_state_t nxt_st;
   logic [1:0] sub_ff;
   logic [1:0] slot_ff;
   logic [10:0] base_ff;
   logic [10:0] iss_cnt_ff;
   logic [10:0] smp_cnt_ff;
   logic rvalid_ff;
   wire in_ts = (st_ff == PTWB_TS);
   wire in_ptr = (st_ff == PTWB_PTR);
   wire in_samp = (st_ff == PTWB_SAMP);
   wire blk_inc = (st_ff == PTWB_DONE);
   wire smp_last = (smp_cnt_ff == win_ff - 11'h001);
   wire [2:0] smp_tag = smp_last ? SEC_TAG_LAST : // [R15]
      (smp_cnt_ff == win_ff - ALMOST_BACK) ? SEC_TAG_ALMOST : // [R16]
      SEC_TAG_SMP;
   assign tq_pop = (in_ts || in_ptr) && has_entry;
   assign issue = in_samp && (iss_cnt_ff != win_ff);

   // secondary write port selection per state
   wire sec_we = (in_ts && has_entry) || (st_ff == PTWB_CNTHI)
                 || (st_ff == PTWB_CNTLO) || (in_samp && rvalid_ff);
   wire [10:0] sec_waddr =
      in_ts ? base_ff + {9'h000, SLOT_LAST - sub_ff} : // [R13]
      (st_ff == PTWB_CNTHI) ? base_ff + CNT_HI_OFS :
      (st_ff == PTWB_CNTLO) ? base_ff + CNT_LO_OFS :
      base_ff + HDR_WORDS + smp_cnt_ff; // [R2]
   wire [WORD_W-1:0] sec_wdata =
      in_ts ? {SEC_TAG_TS, tq_head[11:0]} : // [R13]
      (st_ff == PTWB_CNTHI) ? {SEC_TAG_CNT_HI, trig_num_ff[26:14]} :
      (st_ff == PTWB_CNTLO) ? {SEC_TAG_CNT_LO, trig_num_ff[13:0]} :
      {smp_tag, 1'b0, pri_q_ff}; // [R14] [R15]

   // next-state; queue head drives the engine so it waits for entries
   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         PTWB_IDLE: if (has_entry) nxt_st = PTWB_TS; // [R8]
         PTWB_TS: if (has_entry && sub_ff == SLOT_LAST) nxt_st = PTWB_PTR;
         PTWB_PTR: if (has_entry) nxt_st = PTWB_CNTHI;
         PTWB_CNTHI: nxt_st = PTWB_CNTLO;
         PTWB_CNTLO: nxt_st = (win_ff == 11'h000) ? PTWB_DONE : PTWB_SAMP;
         PTWB_SAMP: if (rvalid_ff && smp_last) nxt_st = PTWB_DONE; // [R10]
         PTWB_DONE: nxt_st = PTWB_IDLE;
         default: nxt_st = PTWB_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_ff <= PTWB_IDLE;
         sub_ff <= 2'h0;
      end else if (ce) begin
         st_ff <= clr ? PTWB_IDLE : nxt_st;
         sub_ff <= (in_ts && has_entry && !clr) ? sub_ff + 2'h1 : 2'h0;
      end
   end

   // sample pipeline: read issued one cycle before its write
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rd_ptr_ff <= 12'h000;
         iss_cnt_ff <= 11'h000;
         smp_cnt_ff <= 11'h000;
         rvalid_ff <= 1'b0;
      end else if (ce) begin
         rvalid_ff <= issue && !clr;
         if (in_ptr && has_entry) begin
            rd_ptr_ff <= tq_head[11:0]; // [R9]
            iss_cnt_ff <= 11'h000;
            smp_cnt_ff <= 11'h000;
         end else begin
            if (issue) rd_ptr_ff <= ring_inc(rd_ptr_ff);
            if (issue) iss_cnt_ff <= iss_cnt_ff + 11'h001;
            if (in_samp && rvalid_ff) begin
               smp_cnt_ff <= smp_cnt_ff + 11'h001; // [R10]
            end
         end
      end
   end

   // fixed slot bases: 0, pitch, 2x, 3x, then back to 0
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         base_ff <= 11'h000;
         slot_ff <= 2'h0;
         trig_num_ff <= 27'h0000000;
      end else if (ce) begin
         if (clr) begin
            base_ff <= 11'h000;
            slot_ff <= 2'h0;
            trig_num_ff <= 27'h0000000;
         end else begin
            if (in_ptr && has_entry) trig_num_ff <= trig_num_ff + 27'h1;
            if (blk_inc) begin
               slot_ff <= slot_ff + 2'h1;
               base_ff <= (slot_ff == SLOT_LAST) ? 11'h000 :
                          base_ff + stride_ff; // [R12] [R4]
            end
         end
      end
   end

   ptwb_sec_ram u_sec (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .we(sec_we),
      .waddr(sec_waddr),
      .wdata(sec_wdata),
      .raddr(sec_rd_addr),
      .rdata(sec_rd_data)
   );

   // ---------------- ready count and sticky flags ----------------
   wire dec_ok = blk_dec && (blocks_ready != 3'h0); // [R11]
   wire [2:0] after_dec = blocks_ready - {2'h0, dec_ok}; // [R17]
   wire [2:0] nxt_rdy = (blk_inc && after_dec != 3'h7) ?
                        after_dec + 3'h1 : after_dec; // [R18]

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         blocks_ready <= 3'h0;
         copy_ovr_ff <= 1'b0;
         blk_ovr_ff <= 1'b0;
      end else if (ce) begin
         if (clr) begin
            blocks_ready <= 3'h0;
            copy_ovr_ff <= 1'b0;
            blk_ovr_ff <= 1'b0;
         end else begin
            blocks_ready <= nxt_rdy;
            if (trig_det && !room) copy_ovr_ff <= 1'b1; // [R19]
            if (blocks_ready == maxblk_ff) blk_ovr_ff <= 1'b1; // [R20]
         end
      end
   end

   // ---------------- assertions ----------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence push_burst_s;
      pushing_ff && ce ##1 pushing_ff [*4];
   endsequence

   ring_wrap_a: assert property (ce && adc_valid && wr_ptr_ff == PRI_LAST
      |=> wr_ptr_ff == 12'h000) // [R1]
      else $error("ring pointer did not wrap");
   start_tag_a: assert property (pushing_ff && push_idx_ff == 3'h0
      |-> push_data[15:12] == 4'hC && push_data[11:0] == ts_cap_ff[11:0])
      else $error("first queue entry not tagged start"); // [R7]
   record_len_a: assert property (trig_take && ce && !clr && !srst_ff
      |=> ##0 push_burst_s ##1 (!pushing_ff || !ce)) // [R6]
      else $error("trigger record not five entries");
   entry_flag_a: assert property (pushing_ff && ce && !clr
      |=> has_entry) // [R8]
      else $error("queue flag low after push");
   ts_word_a: assert property (in_ts && sec_we
      |-> sec_wdata[15:12] == 4'h8 && sec_waddr == base_ff + 11'h003
      - {9'h000, sub_ff}) // [R13]
      else $error("time word tag or order wrong");
   cnt_tags_a: assert property (st_ff == PTWB_CNTHI && ce && !clr
      |-> sec_wdata[15:13] == 3'h2 ##1 sec_wdata[15:14] == 2'h1)
      else $error("trigger count tags wrong"); // [R14]
   last_tag_a: assert property (in_samp && rvalid_ff && smp_last
      |-> sec_wdata[15:13] == 3'h1) // [R15]
      else $error("final sample not tagged last");
   almost_tag_a: assert property (in_samp && rvalid_ff && !smp_last
      && smp_cnt_ff + 11'h005 == win_ff |-> sec_wdata[15:13] == 3'h7)
      else $error("almost-done tag missing"); // [R16]
   first_read_a: assert property (in_ptr && has_entry && ce && !clr
      |=> rd_ptr_ff == $past(tq_head[11:0])) // [R9]
      else $error("copy did not start at queued pointer");
   both_cnt_a: assert property (ce && !clr && blk_inc && blk_dec
      && blocks_ready != 3'h0 |=> $stable(blocks_ready)) // [R17]
      else $error("inc plus dec changed ready count");
   inc_cnt_a: assert property (ce && !clr && blk_inc && !blk_dec
      && blocks_ready != 3'h7 |=> blocks_ready == $past(blocks_ready)
      + 3'h1) // [R18]
      else $error("ready count missed a block");
   ovr_sticky_a: assert property (copy_ovr_ff && !(ce && clr)
      |=> copy_ovr_ff) // [R19]
      else $error("copy overrun flag dropped");
   blk_ovr_a: assert property (ce && !clr && blocks_ready == maxblk_ff
      |=> blk_ovr_ff) // [R20]
      else $error("block overrun not flagged");
   base_slot_a: assert property (blk_inc && ce && !clr
      && slot_ff == SLOT_LAST |=> base_ff == 11'h000) // [R12]
      else $error("slot base did not return to zero");
endmodule
`default_nettype wire

// file: verilog/ptwb_pkg.sv
`default_nettype none
package ptwb_pkg;
   // sample and ring geometry
   localparam int SMP_W = 12;
   localparam int PRI_DEPTH = 4081;
   localparam int PRI_AW = 12;
   localparam logic [11:0] PRI_LAST = 12'hFF0;
   localparam logic [11:0] PRI_DEPTH_W = 12'hFF1;
   // secondary store: 4 trigger slots of fixed pitch
   localparam int SEC_DEPTH = 2040;
   localparam int SEC_AW = 11;
   localparam int WORD_W = 16;
   localparam logic [1:0] SLOT_LAST = 2'h3;
   localparam logic [10:0] HDR_WORDS = 11'h006;
   localparam logic [10:0] CNT_HI_OFS = 11'h004;
   localparam logic [10:0] CNT_LO_OFS = 11'h005;
   localparam logic [10:0] ALMOST_BACK = 11'h005;
   // trigger queue: 4 time slices then the window pointer
   localparam int TQ_AW = 5;
   localparam int TQ_DEPTH = 32;
   localparam logic [5:0] TQ_REC = 6'h05;
   localparam logic [2:0] TQ_LAST_IDX = 3'h4;
   localparam logic [3:0] TQ_TAG_START = 4'hC;
   localparam logic [3:0] TQ_TAG_TS = 4'h4;
   localparam logic [3:0] TQ_TAG_PTR = 4'h0;
   // secondary word tags
   localparam logic [3:0] SEC_TAG_TS = 4'h8;
   localparam logic [2:0] SEC_TAG_CNT_HI = 3'h2;
   localparam logic [1:0] SEC_TAG_CNT_LO = 2'h1;
   localparam logic [2:0] SEC_TAG_SMP = 3'h0;
   localparam logic [2:0] SEC_TAG_LAST = 3'h1;
   localparam logic [2:0] SEC_TAG_ALMOST = 3'h7;
   // apb register byte offsets
   localparam logic [7:0] OFS_WIN = 8'h00;
   localparam logic [7:0] OFS_LAT = 8'h04;
   localparam logic [7:0] OFS_STRIDE = 8'h08;
   localparam logic [7:0] OFS_MAXBLK = 8'h0C;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_TRIGNUM = 8'h18;
   // values after reset
   localparam logic [10:0] WIN_RST = 11'h1F4;
   localparam logic [11:0] LAT_RST = 12'h1F4;
   localparam logic [10:0] STRIDE_RST = 11'h1F8;
   localparam logic [2:0] MAXBLK_RST = 3'h4;
   // copy engine states, gray from idle up to done; done back to idle flips two bits
   typedef enum logic [2:0] {
      PTWB_IDLE = 3'b000,
      PTWB_TS = 3'b001,
      PTWB_PTR = 3'b011,
      PTWB_CNTHI = 3'b010,
      PTWB_CNTLO = 3'b110,
      PTWB_SAMP = 3'b111,
      PTWB_DONE = 3'b101
   } ptwb_state_t;
endpackage
`default_nettype wire

// file: verilog/ptwb_sec_ram.sv
`timescale 1ns/1ns
`default_nettype none
module ptwb_sec_ram (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic we,
   input wire logic [ptwb_pkg::SEC_AW-1:0] waddr,
   input wire logic [ptwb_pkg::WORD_W-1:0] wdata,
   input wire logic [ptwb_pkg::SEC_AW-1:0] raddr,
   output logic [ptwb_pkg::WORD_W-1:0] rdata
);
   import ptwb_pkg::*;
   logic [WORD_W-1:0] mem [SEC_DEPTH];

   // write port owned by the copy engine; no reset on the array
   always_ff @(posedge clk_sys) begin
      if (ce && we && waddr < SEC_AW'(SEC_DEPTH)) begin
         mem[waddr] <= wdata;
      end
   end

   // registered read port for the processing logic, one cycle late
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata <= 16'h0000;
      end else if (ce) begin
         rdata <= (raddr < SEC_AW'(SEC_DEPTH)) ? mem[raddr] : 16'h0000;
      end
   end
endmodule
`default_nettype wire

// file: verilog/ptwb_trig_queue.sv
`timescale 1ns/1ns
`default_nettype none
module ptwb_trig_queue (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic clr,
   input wire logic push,
   input wire logic [ptwb_pkg::WORD_W-1:0] push_data,
   input wire logic pop,
   output logic [ptwb_pkg::WORD_W-1:0] head,
   output logic has_entry,
   output logic [ptwb_pkg::TQ_AW:0] free
);
   import ptwb_pkg::*;
   logic [WORD_W-1:0] mem [TQ_DEPTH];
   logic [TQ_AW-1:0] wp_ff;
   logic [TQ_AW-1:0] rp_ff;
   logic [TQ_AW:0] cnt_ff;
   wire do_push = push && (cnt_ff != (TQ_AW+1)'(TQ_DEPTH));
   wire do_pop = pop && (cnt_ff != '0);

   // head is read straight from the array so the engine pops in one cycle
   assign head = mem[rp_ff];
   assign has_entry = (cnt_ff != '0);
   assign free = (TQ_AW+1)'(TQ_DEPTH) - cnt_ff;

   always_ff @(posedge clk_sys) begin
      if (ce && do_push) begin
         mem[wp_ff] <= push_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end else if (ce) begin
         if (clr) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
         end else begin
            wp_ff <= wp_ff + TQ_AW'(do_push);
            rp_ff <= rp_ff + TQ_AW'(do_pop);
            cnt_ff <= cnt_ff + (TQ_AW+1)'(do_push) - (TQ_AW+1)'(do_pop);
         end
      end
   end
endmodule
`default_nettype wire

// file: verification/ptwb_proc_model.sv
`timescale 1ns/1ns
`default_nettype none
// downstream reader: fetches block words, then retires the block
module ptwb_proc_model (
   input wire logic clk_sys,
   output logic [ptwb_pkg::SEC_AW-1:0] sec_rd_addr,
   input wire logic [ptwb_pkg::WORD_W-1:0] sec_rd_data,
   output logic blk_dec
);
   import ptwb_pkg::*;
   initial begin
      sec_rd_addr = 11'h000;
      blk_dec = 1'b0;
   end
   // read data is registered, so it is taken two edges after the address
   task automatic rd(input logic [10:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      sec_rd_addr <= a;
      @(posedge clk_sys);
      @(posedge clk_sys);
      d = sec_rd_data;
   endtask
   // one pulse per finished block, never more
   task automatic done();
      blk_dec <= 1'b1;
      @(posedge clk_sys);
      blk_dec <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import ptwb_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic pslverr;
   logic er;
   logic trig_n = 1'b1;
   logic adc_valid = 1'b0;
   logic [11:0] adc_data = 12'h000;
   logic blk_dec;
   logic [10:0] sec_rd_addr;
   logic [15:0] sec_rd_data;
   logic [2:0] blocks_ready;
   int fail_count = 0;
   int comparisons = 0;
   int cyc = 0;
   ptwb_window_buffer dut_u (.clk_sys, .rstn, .ce, .paddr, .psel,
      .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .adc_data,
      .adc_valid, .trig_n, .blk_dec, .sec_rd_addr, .sec_rd_data,
      .blocks_ready);
   ptwb_proc_model pm_u (.clk_sys, .sec_rd_addr, .sec_rd_data, .blk_dec);
   always #10 clk_sys = ~clk_sys;
   // ramp samples make any skipped or repeated ring slot visible
   always @(posedge clk_sys) if (adc_valid) adc_data <= adc_data + 12'h001;
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task tally_and_finish();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask
   // setup, access, hold until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // pin low two edges then high two: back to back calls land inside push
   task pulse();
      trig_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      trig_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
   endtask
   task wblk(input logic [2:0] n);
      repeat (300) if (blocks_ready !== n) @(posedge clk_sys);
      chk("blocks", {29'h0, n}, {29'h0, blocks_ready});
   endtask
   // window of 8: header 6 words, almost tag on sample 3, last on 7
   // ramp value equals its ring slot and the stamp runs with the write
   // pointer, so the window opens LAT (8) words before the stamp
   task blk(input logic [10:0] b, input logic [13:0] n);
      logic [15:0] d;
      logic [11:0] p;
      logic [11:0] t;
      p = 12'h000;
      t = 12'h000;
      for (int i = 0; i < 14; i++) begin
         pm_u.rd(b + 11'(i), d);
         if (i == 3) t = d[11:0];
         if (i < 3) chk("ts hi", 32'h8000, {16'h0, d});
         else if (i == 3) chk("ts tag", 32'h8, {28'h0, d[15:12]});
         else if (i == 4) chk("cnt hi", 32'h4000, {16'h0, d});
         else if (i == 5) chk("cnt lo", {18'h1, n}, {16'h0, d});
         else begin
            chk("smp tag", (i == 13) ? 32'h1 : (i == 9) ? 32'h7 : 32'h0,
               {29'h0, d[15:13]});
            if (i == 6)
               chk("start", {20'h0, t - 12'h008}, {20'h0, d[11:0]});
            else
               chk("ramp", {20'h0, p + 12'h001}, {20'h0, d[11:0]});
            p = d[11:0];
         end
      end
   endtask
   task regs_t();
      apb(1'b0, OFS_STRIDE, 32'h0);
      chk("stride rst", 32'h1F8, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h1, {31'h0, er});
      apb(1'b1, OFS_WIN, 32'h8);
      apb(1'b1, OFS_STRIDE, 32'h10);
      apb(1'b1, OFS_LAT, 32'h8);
      apb(1'b1, OFS_MAXBLK, 32'h2);
   endtask
   task copy_t();
      pulse();
      wblk(3'h1);
      blk(11'h000, 14'h0001);
      pulse();
      wblk(3'h2);
      blk(11'h010, 14'h0002);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("blk ovr", 32'h1, {31'h0, rd[4]});
      pm_u.done();
      wblk(3'h1);
   endtask
   task ovr_t();
      pulse();
      pulse();
      wblk(3'h2);
      repeat (40) @(posedge clk_sys);
      chk("one blk", 32'h2, {29'h0, blocks_ready});
      // one frozen edge: the decrement must not land; valid drops too
      // so the ramp stays in step with the frozen write pointer
      ce <= 1'b0;
      adc_valid <= 1'b0;
      pm_u.done();
      ce <= 1'b1;
      adc_valid <= 1'b1;
      @(posedge clk_sys);
      chk("frozen", 32'h2, {29'h0, blocks_ready});
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("ovr flags", 32'h3, {30'h0, rd[5:4]});
      blk(11'h020, 14'h0003);
   endtask
   // at window 8 the count moves 23 edges after the pulse starts, so the
   // decrement is timed onto that same edge; either early or late shows
   task both_t();
      pulse();
      repeat (18) @(posedge clk_sys);
      pm_u.done();
      chk("inc dec", 32'h2, {29'h0, blocks_ready});
      @(posedge clk_sys);
      chk("inc dec", 32'h2, {29'h0, blocks_ready});
      blk(11'h030, 14'h0004);
   endtask
   task srst_t();
      apb(1'b1, OFS_CTRL, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk("blk clr", 32'h0, {29'h0, blocks_ready});
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("flags clr", 32'h0, {30'h0, rd[5:4]});
      apb(1'b0, OFS_WIN, 32'h0);
      chk("win kept", 32'h8, rd);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      adc_valid <= 1'b1;
      regs_t();
      copy_t();
      ovr_t();
      both_t();
      srst_t();
      tally_and_finish();
   end
endmodule
`default_nettype wire
